// File: rtl/ddr_flash_port.sv
// Purpose: Device side of a DDR NOR flash bus: command/address, reads, writes
// Assumes: clk_sys is at least 8x the bus clock; latency code comes from the latency_count input
// Notes: Bus edges are found by oversampling, so strobe and data lag the bus clock
`timescale 1ns/10ps
module ddr_flash_port
  import flash_bus_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic bus_clk,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic read_strobe,
  output logic read_strobe_oe,
  input wire logic [3:0] latency_count,
  output logic [31:0] rd_addr,
  input wire logic [15:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output wr_word_s wr_word,
  output logic write_overrun
);

  port_state_s st;
  port_state_s next_st;
  logic bus_rise;
  logic bus_fall;
  logic cs_fall;
  logic fifo_in_ready;
  logic [47:0] ca_full;
  logic [4:0] lat_clocks;
  logic [5:0] page_off;
  logic [4:0] extra_calc;
  logic [31:0] addr_next;

  // Only the true bus clock is sampled; the complementary clocks add nothing here
  assign bus_rise = st.bclk_s && !st.bclk_d;
  assign bus_fall = !st.bclk_s && st.bclk_d;
  assign cs_fall = st.cs_d && !st.cs_s;
  assign ca_full = {st.ca[39:0], st.dq_s};

  // Reserved codes fall back to the longest latency
  assign lat_clocks = (latency_count > LAT_CODE_MAX) ? LAT_RESERVED
                      : 5'(latency_count) + LAT_BASE;
  assign page_off = {3'b000, ca_full[CA_COL_MSB:0]} & (SUBPAGE_WORDS - 6'd1);
  assign extra_calc = ((PAGE_WORDS - 6'(lat_clocks)) < page_off)
                      ? 5'(page_off - PAGE_WORDS + 6'(lat_clocks)) : 5'h00;

  // Wrapped reads stay inside the current page
  assign addr_next = st.linear ? st.addr + 32'h1
                     : {st.addr[31:4], st.addr[3:0] + 4'h1};

  always_comb begin
    next_st = st;
    next_st.bclk_m = bus_clk;
    next_st.bclk_s = st.bclk_m;
    next_st.bclk_d = st.bclk_s;
    next_st.cs_m = cs_n;
    next_st.cs_s = st.cs_m;
    next_st.cs_d = st.cs_s;
    next_st.dq_m = dq_in;
    next_st.dq_s = st.dq_m;
    if (st.pend_valid && fifo_in_ready) begin
      next_st.pend_valid = 1'b0;
    end
    case (st.state)
      S_IDLE: begin
        if (cs_fall) begin
          next_st.state = S_CA;
          next_st.ca_cnt = 3'h0;
          next_st.crossed = 1'b0;
          next_st.strobe_oe = 1'b1;
          next_st.strobe = 1'b0;
        end
      end
      S_CA: begin
        if (bus_rise || bus_fall) begin
          next_st.ca = ca_full;
          next_st.ca_cnt = st.ca_cnt + 3'h1;
          if (st.ca_cnt == CA_LAST_IDX) begin
            next_st.is_read = ca_full[CA_RW_BIT];
            next_st.linear = ca_full[CA_BURST_BIT] && ca_full[CA_RW_BIT];
            next_st.addr = {ca_full[CA_ROW_MSB:CA_ROW_LSB], ca_full[CA_COL_MSB:0]};
            next_st.extra = extra_calc;
            next_st.wait_cnt = lat_clocks - LAT_CA_OVERLAP;
            next_st.state = ca_full[CA_RW_BIT] ? S_WAIT : S_WDATA;
          end
        end
      end
      S_WAIT: begin
        if (bus_rise) begin
          if (st.wait_cnt == 5'h00) begin
            next_st.state = S_RDATA;
            next_st.dq_out = rd_data[15:8];
            next_st.lo_hold = rd_data[7:0];
            next_st.dq_oe = 1'b1;
            next_st.strobe = 1'b1;
          end else begin
            next_st.wait_cnt = st.wait_cnt - 5'h01;
          end
        end
      end
      S_RDATA: begin
        if (bus_rise) begin
          next_st.dq_out = rd_data[15:8];
          next_st.lo_hold = rd_data[7:0];
          next_st.strobe = 1'b1;
        end else if (bus_fall) begin
          next_st.dq_out = st.lo_hold;
          next_st.strobe = 1'b0;
          next_st.addr = addr_next;
          // Strobe stays low through the boundary wait so no stale word is clocked in
          if (st.linear && !st.crossed && addr_next[3:0] == 4'h0) begin
            next_st.crossed = 1'b1;
            if (st.extra != 5'h00) begin
              next_st.state = S_WAIT;
              next_st.wait_cnt = st.extra;
            end
          end
        end
      end
      S_WDATA: begin
        if (bus_rise) begin
          next_st.hi_byte = st.dq_s;
        end else if (bus_fall) begin
          if (st.pend_valid && !fifo_in_ready) begin
            next_st.overrun = 1'b1;
          end else begin
            next_st.pend = '{addr: st.addr, data: {st.hi_byte, st.dq_s}};
            next_st.pend_valid = 1'b1;
          end
          next_st.addr = st.addr + 32'h1;
        end
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase
    // A partial word is dropped when chip select rises mid-transfer
    if (st.cs_s) begin
      next_st.state = S_IDLE;
      next_st.dq_oe = 1'b0;
      next_st.strobe = 1'b0;
      next_st.strobe_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= PORT_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  word_fifo #(
    .WIDTH($bits(wr_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(st.pend_valid),
    .in_ready(fifo_in_ready),
    .in_data(st.pend),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  assign dq_out = st.dq_out;
  assign dq_oe = st.dq_oe;
  assign read_strobe = st.strobe;
  assign read_strobe_oe = st.strobe_oe;
  assign rd_addr = st.addr;
  assign write_overrun = st.overrun;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !clk_en);

  // Latency rebuilt from the raw code so the checks do not lean on lat_clocks
  function automatic int lat_ref(logic [3:0] code);
    return (code > LAT_CODE_MAX) ? int'(LAT_RESERVED) : int'(code) + int'(LAT_BASE);
  endfunction

  function automatic int extra_ref(int off, int lat);
    return ((int'(PAGE_WORDS) - lat) < off) ? off - int'(PAGE_WORDS) + lat : 0;
  endfunction

  sequence s_ca_done;
    st.state == S_CA && st.ca_cnt == CA_LAST_IDX && (bus_rise || bus_fall) && !st.cs_s;
  endsequence

  property p_ca_three;
    (st.state == S_WDATA && $past(st.state) == S_CA) |-> $past(st.ca_cnt) == CA_LAST_IDX;
  endproperty
  a_ca_three: assert property (p_ca_three) else $error("data phase before six CA bytes");

  property p_extra_formula;
    s_ca_done ##1 (st.state == S_WAIT) |->
      int'(st.extra) == extra_ref(int'(st.addr[2:0]), lat_ref(latency_count));
  endproperty
  a_extra_formula: assert property (p_extra_formula) else $error("bad boundary extra");

  property p_latency_load;
    s_ca_done ##1 (st.state == S_WAIT) |->
      int'(st.wait_cnt) == lat_ref(latency_count) - int'(LAT_CA_OVERLAP);
  endproperty
  a_latency_load: assert property (p_latency_load) else $error("bad initial latency");

  property p_wait_on_crossing;
    (st.state == S_WAIT && $past(st.state) == S_RDATA) |->
      st.linear && st.is_read && st.addr[3:0] == 4'h0 && !st.strobe;
  endproperty
  a_wait_on_crossing: assert property (p_wait_on_crossing) else $error("bad boundary wait");

  property p_write_strobe_low;
    (st.state == S_WDATA) |-> read_strobe_oe && !read_strobe && !dq_oe;
  endproperty
  a_write_strobe_low: assert property (p_write_strobe_low) else $error("strobe not low");

  property p_read_drive;
    (st.state == S_RDATA) |-> read_strobe_oe && dq_oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");

  property p_cs_end;
    (st.cs_s && st.state != S_IDLE) |=> st.state == S_IDLE && !dq_oe && !read_strobe_oe;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("transfer not ended");

  property p_write_no_burst;
    (st.state == S_WDATA) |-> !st.linear;
  endproperty
  a_write_no_burst: assert property (p_write_no_burst) else $error("burst bit used on write");

  property p_write_push;
    (st.state == S_WDATA && bus_fall && !st.cs_s && !(st.pend_valid && !fifo_in_ready))
      |=> st.pend_valid && st.pend.data[7:0] == $past(st.dq_s) && st.addr == st.pend.addr + 32'h1;
  endproperty
  a_write_push: assert property (p_write_push) else $error("write word not queued");

endmodule

// File: rtl/flash_bus_pkg.sv
// Purpose: Shared types and constants for the DDR flash bus port
// Assumes: 20 MHz system clock oversamples a bus clock of 400 ns or slower
// Notes: Bus pins are synchronised inside the port; no software registers
package flash_bus_pkg;

  localparam int SYS_CLK_NS = 50;
  localparam int BUS_CLK_NS = 400;

  // Transfer geometry
  localparam logic [5:0] PAGE_WORDS = 6'd16;
  localparam logic [5:0] SUBPAGE_WORDS = 6'd8;
  localparam logic [2:0] CA_LAST_IDX = 3'd5;
  localparam int CA_RW_BIT = 47;
  localparam int CA_BURST_BIT = 45;
  localparam int CA_ROW_MSB = 44;
  localparam int CA_ROW_LSB = 16;
  localparam int CA_COL_MSB = 2;

  // Latency code to clock count; codes above LAT_CODE_MAX are reserved
  localparam logic [3:0] LAT_CODE_MAX = 4'hb;
  localparam logic [4:0] LAT_BASE = 5'd5;
  localparam logic [4:0] LAT_RESERVED = 5'd16;
  localparam logic [4:0] LAT_CA_OVERLAP = 5'd2;

  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CA = 3'b001,
    S_WAIT = 3'b010,
    S_RDATA = 3'b011,
    S_WDATA = 3'b100
  } bus_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
  } wr_word_s;

  typedef struct packed {
    logic bclk_m;
    logic bclk_s;
    logic bclk_d;
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic [7:0] dq_m;
    logic [7:0] dq_s;
    bus_state_e state;
    logic [2:0] ca_cnt;
    logic [47:0] ca;
    logic is_read;
    logic linear;
    logic [31:0] addr;
    logic [4:0] wait_cnt;
    logic [4:0] extra;
    logic crossed;
    logic [7:0] hi_byte;
    logic [7:0] lo_hold;
    logic pend_valid;
    wr_word_s pend;
    logic overrun;
    logic [7:0] dq_out;
    logic dq_oe;
    logic strobe;
    logic strobe_oe;
  } port_state_s;

  localparam port_state_s PORT_RESET = '{
    bclk_m: 1'b0, bclk_s: 1'b0, bclk_d: 1'b0,
    cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1,
    dq_m: 8'h00, dq_s: 8'h00, state: S_IDLE, ca_cnt: 3'h0, ca: 48'h0,
    is_read: 1'b0, linear: 1'b0, addr: 32'h0, wait_cnt: 5'h00, extra: 5'h00,
    crossed: 1'b0, hi_byte: 8'h00, lo_hold: 8'h00, pend_valid: 1'b0,
    pend: '0, overrun: 1'b0, dq_out: 8'h00, dq_oe: 1'b0, strobe: 1'b0,
    strobe_oe: 1'b0
  };

endpackage

// File: rtl/word_fifo.sv
// Purpose: Synchronous valid/ready FIFO for completed write words
// Assumes: DEPTH is a power of two
// Notes: Full and empty are registered so the flags never glitch
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic full;
    logic empty;
  } fifo_state_s;

  fifo_state_s st;
  fifo_state_s next_st;
  logic push;
  logic pop;

  assign push = in_valid && !st.full;
  assign pop = out_ready && !st.empty;
  assign in_ready = !st.full;
  assign out_valid = !st.empty;
  assign out_data = st.mem[st.rd_ptr];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    next_st.count = st.count + (PW + 1)'(push) - (PW + 1)'(pop);
    next_st.full = (next_st.count == (PW + 1)'(DEPTH));
    next_st.empty = (next_st.count == '0);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0, empty: 1'b1};
    end else if (clk_en) begin
      st <= next_st;
    end
  end
endmodule

// File: verification/host_model.sv
// Purpose: Behavioural host controller that frames transfers on the DDR flash bus
// Assumes: Bus clock period 400 ns, started off the system clock edges
// Notes: Released data lines show the inverse of the last value, never a stale copy
`timescale 1ns/10ps
module host_model (
  output logic cs_n,
  output logic bus_clk,
  output logic [7:0] host_dq
);
  int cyc;

  initial begin
    cs_n = 1'b1;
    bus_clk = 1'b0;
    host_dq = 8'h00;
    cyc = 0;
  end

  // Byte placed a quarter period before its edge, so it is centred on the edge
  task automatic half(input logic [7:0] b);
    host_dq = b;
    #100;
    bus_clk = ~bus_clk;
    if (bus_clk) cyc++;
    #100;
  endtask

  task automatic frame(input logic [47:0] ca, input logic [7:0] data[$], input int idle);
    #13;
    cyc = -1;
    cs_n = 1'b0;
    #100;
    for (int i = 5; i >= 0; i--) half(ca[i*8 +: 8]);
    foreach (data[i]) half(data[i]);
    for (int i = 0; i < idle; i++) half(~host_dq);
    #300;
    host_dq = ~host_dq;
    cs_n = 1'b1;
    #300;
  endtask
endmodule

// File: verification/testbench.sv
// Purpose: Self-checking bench for the DDR flash bus port
// Assumes: Word at address w is {w[7:0] ^ a5, w[7:0]} from the memory stub
// Notes: Read bytes are timed by the host cycle count seen at each strobe rise
`timescale 1ns/10ps
module testbench;
  import flash_bus_pkg::*;
  logic clk_sys, rst, clk_en, cs_n, bus_clk, dq_oe, read_strobe, read_strobe_oe;
  logic wr_valid, wr_ready, write_overrun, in_wr, prev_strobe, stall;
  logic [7:0] dq_in, dq_out, host_dq;
  logic [3:0] latency_count;
  logic [31:0] rd_addr;
  logic [15:0] rd_data;
  logic [16:0] exp_rd;
  wr_word_s wr_word;
  logic [47:0] wq[$];
  logic [16:0] rq[$];
  int bad_count, checked;

  ddr_flash_port i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .cs_n(cs_n),
    .bus_clk(bus_clk), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .read_strobe(read_strobe), .read_strobe_oe(read_strobe_oe),
    .latency_count(latency_count), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
    .write_overrun(write_overrun));
  host_model i_host (.cs_n(cs_n), .bus_clk(bus_clk), .host_dq(host_dq));

  assign dq_in = dq_oe ? dq_out : host_dq;
  assign rd_data = {rd_addr[7:0] ^ 8'ha5, rd_addr[7:0]};

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d, bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_empty();
    int t;
    for (t = 0; t < 400 && rq.size() + wq.size() != 0; t++) @(posedge clk_sys);
    if (t == 400) begin
      chk(1'b1, 1'b0);
      finish_test();
    end
  endtask

  // Result watcher: every strobe edge while dq_oe is high and every drained word retires one note
  always @(posedge clk_sys) begin
    prev_strobe <= read_strobe;
    wr_ready <= !stall && $urandom_range(1, 0) == 1;
    if (in_wr) chk(read_strobe, 1'b0);
    if (dq_oe === 1'b1 && read_strobe !== prev_strobe) begin
      exp_rd = rq.size() ? rq.pop_front() : 17'h1ffff;
      chk({read_strobe_oe, read_strobe ? i_host.cyc[7:0] : 8'h00, dq_out}, exp_rd);
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (wq.size() == 0) chk(1'b1, 1'b0);
      else chk(wr_word, wq.pop_front());
    end
  end

  task automatic rd_test(input logic [3:0] code, input logic [31:0] a, input logic lin,
                         input int n);
    int lat, ex, c;
    logic [31:0] wa;
    logic [7:0] none[$];
    @(posedge clk_sys);
    latency_count <= code;
    lat = code > 4'hb ? 16 : code + 5;
    ex = (lin && a[2:0] > 16 - lat) ? a[2:0] - 16 + lat : 0;
    for (int k = 0; k < n; k++) begin
      wa = lin ? a + k : {a[31:4], a[3:0] + k[3:0]};
      c = lat + 1 + k + ((lin && a[3:0] + k >= 16) ? ex : 0);
      rq.push_back({1'b1, c[7:0], wa[7:0] ^ 8'ha5});
      rq.push_back({1'b1, 8'h00, wa[7:0]});
    end
    i_host.frame({2'b10, lin, a[31:3], 13'h0, a[2:0]}, none, 2 * (c + 1) - 6);
    wait_empty();
  endtask

  task automatic wr_test(input logic [31:0] a, input int n, input int keep);
    logic [7:0] b[$];
    logic [15:0] d;
    logic bt;
    bt = $urandom_range(1, 0);
    for (int k = 0; k < n; k++) begin
      d = $urandom();
      b.push_back(d[15:8]);
      b.push_back(d[7:0]);
      if (k < keep) wq.push_back({a + k, d});
    end
    in_wr <= 1'b1;
    i_host.frame({2'b00, bt, a[31:3], 13'h0, a[2:0]}, b, 0);
    in_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    in_wr = 1'b0;
    stall = 1'b0;
    wr_ready = 1'b0;
    latency_count = 4'h0;
    bad_count = 0;
    checked = 0;
    void'($urandom(32'h05e5));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({dq_oe, read_strobe, read_strobe_oe, wr_valid, write_overrun, rd_addr}, 37'h0);
    rd_test(4'h0, 32'h0, 1'b1, 4);
    rd_test(4'hb, 32'h0012_3453, 1'b1, 16);
    rd_test(4'hc, 32'h0000_0105, 1'b1, 14);
    rd_test(4'h7, 32'h0000_0046, 1'b0, 20);
    rd_test(4'($urandom_range(11, 0)), $urandom(), 1'b1, 12);
    wr_test($urandom(), 1, 1);
    wr_test($urandom(), 0, 0);
    wr_test($urandom(), 3, 3);
    wait_empty();
    stall <= 1'b1;
    wr_test(32'h0004_5678, 10, 9);
    chk(write_overrun, 1'b1);
    stall <= 1'b0;
    wait_empty();
    finish_test();
  end
endmodule
